//--- include/poe_ctl_pkg.sv
// Purpose: shared constants and types for the per-port power/class control
// Assumes: 10 MHz clock; count-up tick period is a multiple of the clock
// Notes:   current thresholds are in mA as measured by the class ADC
package poe_ctl_pkg;

  // ---------------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_MANUAL   = 2'b01,
    MODE_SEMIAUTO = 2'b10,
    MODE_AUTO     = 2'b11
  } op_mode_e;

  // ---------------------------------------------------------------------
  // classification current bands (mA)
  // ---------------------------------------------------------------------
  localparam logic [7:0] CLS0_MAX_MA = 8'h05;
  localparam logic [7:0] CLS1_MIN_MA = 8'h08;
  localparam logic [7:0] CLS1_MAX_MA = 8'h0D;
  localparam logic [7:0] CLS2_MIN_MA = 8'h10;
  localparam logic [7:0] CLS2_MAX_MA = 8'h15;
  localparam logic [7:0] CLS3_MIN_MA = 8'h19;
  localparam logic [7:0] CLS3_MAX_MA = 8'h1F;
  localparam logic [7:0] CLS4_MIN_MA = 8'h23;
  localparam logic [7:0] CLS4_MAX_MA = 8'h2D;

  localparam logic [2:0] CLASS_0       = 3'h0;
  localparam logic [2:0] CLASS_1       = 3'h1;
  localparam logic [2:0] CLASS_2       = 3'h2;
  localparam logic [2:0] CLASS_3       = 3'h3;
  localparam logic [2:0] CLASS_4       = 3'h4;
  localparam logic [2:0] CLASS_INVALID = 3'h7;

  // ---------------------------------------------------------------------
  // timing configuration field and timer
  // ---------------------------------------------------------------------
  localparam int         OC_SEL_LSB     = 2;
  localparam int         OC_SEL_MSB     = 3;
  localparam int         OC_CNT_W       = 12;
  localparam int         SLOW_DIV       = 16;
  localparam int         CLK_HZ         = 10_000_000;
  localparam int         TICK_US        = 50;
  localparam int         TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
  // full counts for the four overcurrent timeout settings (ticks)
  localparam logic [11:0] OC_FULL_0     = 12'h03C0;
  localparam logic [11:0] OC_FULL_1     = 12'h01E0;
  localparam logic [11:0] OC_FULL_2     = 12'h0780;
  localparam logic [11:0] OC_FULL_3     = 12'h0F00;
  localparam logic [7:0]  TIMING_RST    = 8'h00;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       det_good;     // detection cycle finished with good result
    logic       class_done;   // class measurement valid this cycle
    logic [7:0] class_ma;     // measured class current
  } probe_in_s;

  typedef struct packed {
    logic [2:0] class_code;
    logic       powered;
    logic       oc_fault;
    logic       oc_blocked;
  } port_stat_s;

endpackage

//--- rtl/oc_duty_timer.sv
// Purpose: up/down overcurrent timer with slow countdown and expiry flag
// Assumes: tick is a one-cycle pulse on clk
// Notes:   one counter serves both directions; a divide-by-16 prescaler paces only the countdown
`timescale 1ns/10ps
module oc_duty_timer
  import poe_ctl_pkg::*;
#(
  parameter int W = OC_CNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         over,
  input  wire logic [W-1:0] full,
  output logic              expired,
  output logic              zero,
  output logic [W-1:0]      count
);

  logic [3:0]   pre_ff;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ---------------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 4'h0;
    end else if (tick) begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  // ---------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    if (tick) begin
      if (over) begin
        if (cnt_ff < full) begin
          nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
      end else if (pre_ff == 4'hF && cnt_ff != '0) begin
        nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired = (cnt_ff >= full);
  assign zero    = (cnt_ff == '0);
  assign count   = cnt_ff;

endmodule

//--- rtl/poe_class_overcurrent_timer.sv
// Operation
// - current bands 0-5, 8-13, 16-21, 25-31, 35-45 mA give classes 0..4
// - class 4 is reserved and is granted class 0 power
// - semiauto/auto classify right after good detection; manual on command
// - decoded class is written to the class status field at the end
// - auto mode powers the port after classification, any class
// - no classification in shutdown, when powered, or class enable clear
// - power on enables gate pull-up; power off selects gate pull-down
// - timer counts up while sensed current exceeds the cut level
// - timer also counts up while output is above power-good level
// - on expiry power is removed at once and the fault bit set
// - timeout length selected by timing configuration bits 3:2
// - without overcurrent or power-good level, timer counts down at one sixteenth rate
// - countdown saturates at zero, never wraps
// - full count means timeout expired
// - after expiry timer drains slowly; no repower until zero
// - manual/semiauto honour power-on only if issued after timer is zero
// - auto repowers only after fresh detection begun after timer zero
// - start-up or overcurrent fault removes power in every mode
// - shutdown disables port and clears event, status (not oc_blocked) and enable bits
//
// Purpose: one port's classification sequencing, gate control, oc timer
// Assumes: probe inputs and commands are synchronous pulses on clk;
//          sense comparators are asynchronous and are synchronised here
// Notes:   analog current limit, foldback and start-up timing live outside
`timescale 1ns/10ps
module poe_class_overcurrent_timer
  import poe_ctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire op_mode_e   op_mode,
  input  wire logic       class_enable,
  input  wire logic       detect_enable,
  input  wire logic [7:0] timing_cfg,
  input  wire logic       cmd_classify,
  input  wire logic       cmd_power_on,
  input  wire logic       cmd_power_off,
  input  wire logic       fault_clear,
  input  wire logic       startup_fault,
  input  wire probe_in_s  probe,
  input  wire logic       overcurrent_cut_level,
  input  wire logic       power_good_voltage_level,
  output logic            class_start,
  output logic            gate_pull_up,
  output logic            gate_pull_down,
  output logic            oc_fault_event,
  output logic            det_enable_eff,
  output logic            class_enable_eff,
  output port_stat_s      status,
  output logic [2:0]      power_class
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLASS = 2'b01,
    ST_ON    = 2'b10
  } port_st_e;

  port_st_e    st_ff;
  logic [1:0]  oc_meta_ff;
  logic [1:0]  oc_sync_ff;
  logic [1:0]  pg_meta_ff;
  logic [1:0]  pg_sync_ff;
  logic [15:0] tick_cnt_ff;
  logic        tick_ff;
  logic [2:0]  class_ff;
  logic        fault_ff;
  logic        fresh_ok_ff;
  logic        class_start_ff;
  logic        on_ff;
  logic        shutdown;
  logic        over;
  logic        expired;
  logic        oc_zero;
  logic [11:0] oc_full;
  logic [2:0]  decoded;
  logic        may_classify;
  logic        power_req;
  logic        power_drop;

  assign shutdown = (op_mode == MODE_SHUTDOWN);

  // ---------------------------------------------------------------------
  // comparator synchronisers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_meta_ff <= 2'b00;
      oc_sync_ff <= 2'b00;
    end else begin
      oc_meta_ff <= {oc_meta_ff[0], overcurrent_cut_level};
      oc_sync_ff <= {oc_sync_ff[0], power_good_voltage_level};
    end
  end

  // third and fourth stages, only the third is read; first two stages are read by nothing else
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_meta_ff <= 2'b00;
      pg_sync_ff <= 2'b00;
    end else begin
      pg_meta_ff <= {pg_meta_ff[0], oc_meta_ff[1]};
      pg_sync_ff <= {pg_sync_ff[0], oc_sync_ff[1]};
    end
  end

  // both conditions feed the up count; only meaningful while powered
  assign over = on_ff & (pg_meta_ff[0] | pg_sync_ff[0]);

  // ---------------------------------------------------------------------
  // count-up tick
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      tick_ff     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // timeout selection and timer
  // ---------------------------------------------------------------------
  always_comb begin
    unique case (timing_cfg[OC_SEL_MSB:OC_SEL_LSB])
      2'b00: oc_full = OC_FULL_0;
      2'b01: oc_full = OC_FULL_1;
      2'b10: oc_full = OC_FULL_2;
      2'b11: oc_full = OC_FULL_3;
    endcase
  end

  oc_duty_timer #(
    .W (OC_CNT_W)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (tick_ff),
    .over    (over),
    .full    (oc_full),
    .expired (expired),
    .zero    (oc_zero),
    .count   ()
  );

  // ---------------------------------------------------------------------
  // class decode
  // ---------------------------------------------------------------------
  always_comb begin
    if (probe.class_ma <= CLS0_MAX_MA) begin
      decoded = CLASS_0;
    end else if (probe.class_ma >= CLS1_MIN_MA &&
                 probe.class_ma <= CLS1_MAX_MA) begin
      decoded = CLASS_1;
    end else if (probe.class_ma >= CLS2_MIN_MA &&
                 probe.class_ma <= CLS2_MAX_MA) begin
      decoded = CLASS_2;
    end else if (probe.class_ma >= CLS3_MIN_MA &&
                 probe.class_ma <= CLS3_MAX_MA) begin
      decoded = CLASS_3;
    end else if (probe.class_ma >= CLS4_MIN_MA &&
                 probe.class_ma <= CLS4_MAX_MA) begin
      decoded = CLASS_4;
    end else begin
      decoded = CLASS_INVALID;
    end
  end

  // reserved class 4 is granted class 0 power
  assign power_class = (class_ff == CLASS_4) ? CLASS_0 : class_ff;

  // ---------------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------------
  assign may_classify = !shutdown && !on_ff && class_enable;

  // a fresh good detection or a post-drain command is needed to repower
  assign power_req =
    (op_mode == MODE_AUTO) ? (st_ff == ST_CLASS && probe.class_done &&
                              fresh_ok_ff)
                           : (cmd_power_on && oc_zero && !shutdown);

  assign power_drop = shutdown || cmd_power_off || expired ||
                      startup_fault;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff          <= ST_IDLE;
      class_start_ff <= 1'b0;
    end else begin
      class_start_ff <= 1'b0;
      unique case (st_ff)
        ST_IDLE: begin
          if (may_classify &&
              ((op_mode != MODE_MANUAL && probe.det_good) ||
               (op_mode == MODE_MANUAL && cmd_classify))) begin
            st_ff          <= ST_CLASS;
            class_start_ff <= 1'b1;
          end
        end
        ST_CLASS: begin
          if (shutdown || on_ff) begin
            st_ff <= ST_IDLE;
          end else if (probe.class_done) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_ON: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // detection counts as fresh only if it began with the timer drained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fresh_ok_ff <= 1'b0;
    end else if (shutdown || !oc_zero || on_ff) begin
      fresh_ok_ff <= 1'b0;
    end else if (probe.det_good) begin
      fresh_ok_ff <= 1'b1;
    end
  end

  // class status field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      class_ff <= CLASS_0;
    end else if (shutdown) begin
      class_ff <= CLASS_0;
    end else if (st_ff == ST_CLASS && probe.class_done) begin
      class_ff <= decoded;
    end
  end

  // ---------------------------------------------------------------------
  // power and gate drive
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_ff <= 1'b0;
    end else if (power_drop) begin
      on_ff <= 1'b0;
    end else if (power_req && !expired) begin
      on_ff <= 1'b1;
    end
  end

  assign gate_pull_up   = on_ff;
  assign gate_pull_down = !on_ff;

  // ---------------------------------------------------------------------
  // fault event; a new expiry wins over a clear in the same cycle
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_ff <= 1'b0;
    end else if (on_ff && expired) begin
      fault_ff <= 1'b1;
    end else if (shutdown || fault_clear) begin
      fault_ff <= 1'b0;
    end
  end

  assign oc_fault_event   = fault_ff;
  assign class_start      = class_start_ff;
  assign det_enable_eff   = detect_enable && !shutdown;
  assign class_enable_eff = class_enable && !shutdown;

  assign status.class_code = class_ff;
  assign status.powered    = on_ff;
  assign status.oc_fault   = fault_ff;
  assign status.oc_blocked = !oc_zero;

endmodule

//--- tb/poe_pd_model.sv
// Purpose: stand-in for the powered device on the far side of one port
// Assumes: bench drives its requests on the rising clock edge
// Notes:   class sample is garbage outside its strobe on purpose
`timescale 1ns/10ps
module poe_pd_model
  import poe_ctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       det_req,
  input  wire logic [7:0] load_ma,
  input  wire logic       slow,
  input  wire logic       oc_req,
  input  wire logic       pg_req,
  input  wire logic       class_start,
  input  wire logic       gate_pull_up,
  output probe_in_s       probe,
  output logic            overcurrent_cut_level,
  output logic            power_good_voltage_level
);
  logic [2:0] wait_ff;

  // an unpowered load draws nothing and shows no output voltage
  assign overcurrent_cut_level    = gate_pull_up & oc_req;
  assign power_good_voltage_level = gate_pull_up & pg_req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      probe   <= '0;
      wait_ff <= 3'h0;
    end else begin
      probe.det_good   <= det_req;
      probe.class_done <= (wait_ff == 3'h1);
      // a stale sample is inverted so it never passes for a fresh one
      probe.class_ma   <= (wait_ff == 3'h1) ? load_ma : ~probe.class_ma;
      if (class_start)
        wait_ff <= slow ? 3'h6 : 3'h1;
      else if (wait_ff != 3'h0)
        wait_ff <= wait_ff - 3'h1;
    end
  end
endmodule

//--- tb/poe_class_overcurrent_timer_chk.sv
// Purpose: pin-level relations of the port control block
// Assumes: one clock domain, async active-low reset
// Notes:   timer spans are judged by the bench, not here
`timescale 1ns/10ps
module poe_class_overcurrent_timer_chk
  import poe_ctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire op_mode_e   op_mode,
  input wire logic       class_enable,
  input wire logic       detect_enable,
  input wire logic       fault_clear,
  input wire probe_in_s  probe,
  input wire logic       class_start,
  input wire logic       gate_pull_up,
  input wire logic       gate_pull_down,
  input wire logic       oc_fault_event,
  input wire logic       det_enable_eff,
  input wire logic       class_enable_eff,
  input wire port_stat_s status,
  input wire logic [2:0] power_class
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---
  // trip steps
  // ---
  sequence s_trip;
    $past(gate_pull_up) && !gate_pull_up && oc_fault_event;
  endsequence
  sequence s_held_off;
    !gate_pull_up && status.oc_blocked ##1 !gate_pull_up;
  endsequence

  gate_pair_a: assert property (
    gate_pull_up != gate_pull_down) else $error("gate drives agree");
  class_gated_a: assert property (
    class_start |-> $past(class_enable_eff) && !$past(status.powered))
    else $error("classification while blocked");
  class_pulse_a: assert property (
    class_start |=> !class_start) else $error("class start too long");
  class_eff_a: assert property (
    class_enable_eff == (class_enable && op_mode != MODE_SHUTDOWN))
    else $error("class enable gating wrong");
  det_eff_a: assert property (
    det_enable_eff == (detect_enable && op_mode != MODE_SHUTDOWN))
    else $error("detect enable gating wrong");
  shutdown_clear_a: assert property (
    op_mode == MODE_SHUTDOWN |=> !gate_pull_up && !oc_fault_event
    && status.class_code == CLASS_0) else $error("shutdown left state");
  trip_off_a: assert property (
    $rose(oc_fault_event) |-> s_trip ##0 s_held_off)
    else $error("expiry did not remove power");
  fault_drop_a: assert property (
    $fell(oc_fault_event) |-> $past(fault_clear)
    || $past(op_mode) == MODE_SHUTDOWN) else $error("fault lost");
  no_repower_a: assert property (
    $rose(gate_pull_up) |-> !$past(status.oc_blocked))
    else $error("power on while timer busy");
  class_map_a: assert property (
    power_class == (status.class_code == CLASS_4 ? CLASS_0
    : status.class_code)) else $error("power class mapping wrong");
  class_upd_a: assert property (
    $changed(status.class_code) |-> $past(probe.class_done)
    || $past(op_mode) == MODE_SHUTDOWN) else $error("class code moved");
endmodule

bind poe_class_overcurrent_timer poe_class_overcurrent_timer_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) i_chk (
  .clk(clk), .rst_n(rst_n), .op_mode(op_mode),
  .class_enable(class_enable), .detect_enable(detect_enable),
  .fault_clear(fault_clear), .probe(probe), .class_start(class_start),
  .gate_pull_up(gate_pull_up), .gate_pull_down(gate_pull_down),
  .oc_fault_event(oc_fault_event), .det_enable_eff(det_enable_eff),
  .class_enable_eff(class_enable_eff), .status(status),
  .power_class(power_class)
);

//--- tb/poe_class_overcurrent_timer_tb.sv
// Purpose: self-checking bench for the port control block
// Assumes: 10 MHz clock, timer tick shortened to two cycles
// Notes:   classes and timer spans come from integer models here
`timescale 1ns/10ps
module poe_class_overcurrent_timer_tb
  import poe_ctl_pkg::*;
();
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  op_mode_e   op_mode = MODE_SHUTDOWN;
  logic       class_enable = 1'h1;
  logic [7:0] timing_cfg = 8'h00;
  logic [7:0] load_ma = 8'h00;
  logic [7:0] lf = 8'h41;
  logic       detect_enable = 1'h0, cmd_classify = 1'h0, cmd_power_on = 1'h0;
  logic       cmd_power_off = 1'h0, fault_clear = 1'h0, startup_fault = 1'h0;
  logic       det_req = 1'h0, slow = 1'h0, oc_req = 1'h0, pg_req = 1'h0;
  logic       ocl, pgl, class_start, gate_pull_up, gate_pull_down;
  logic       oc_fault_event, det_enable_eff, class_enable_eff;
  logic [2:0] power_class, e;
  probe_in_s  probe;
  port_stat_s status;
  int         fails = 0, check_count = 0, starts = 0, n, s0;
  int         ma_q[$] = '{0, 5, 6, 8, 13, 14, 16, 21, 25, 31, 35, 45, 46};
  int         full_q[$] = '{960, 480, 1920, 3840};
  int         sel_q[$] = '{0, 2, 3, 1};

  always #50 clk = ~clk;
  always @(posedge clk)
    if (class_start)
      starts <= starts + 1;

  poe_class_overcurrent_timer #(.TICK_CYCLES(2)) i_poe_class_overcurrent_timer (
    .clk(clk), .rst_n(rst_n), .op_mode(op_mode), .class_enable(class_enable),
    .detect_enable(detect_enable), .timing_cfg(timing_cfg),
    .cmd_classify(cmd_classify), .cmd_power_on(cmd_power_on),
    .cmd_power_off(cmd_power_off), .fault_clear(fault_clear),
    .startup_fault(startup_fault), .probe(probe),
    .overcurrent_cut_level(ocl), .power_good_voltage_level(pgl),
    .class_start(class_start), .gate_pull_up(gate_pull_up),
    .gate_pull_down(gate_pull_down), .oc_fault_event(oc_fault_event),
    .det_enable_eff(det_enable_eff), .class_enable_eff(class_enable_eff),
    .status(status), .power_class(power_class));
  poe_pd_model i_poe_pd_model (
    .clk(clk), .rst_n(rst_n), .det_req(det_req), .load_ma(load_ma),
    .slow(slow), .oc_req(oc_req), .pg_req(pg_req), .class_start(class_start),
    .gate_pull_up(gate_pull_up), .probe(probe),
    .overcurrent_cut_level(ocl), .power_good_voltage_level(pgl));

  // ---
  // models and helpers
  // ---
  function automatic logic [2:0] exp_class(input int ma);
    if (ma <= 5) return 3'h0;
    if (ma >= 8 && ma <= 13) return 3'h1;
    if (ma >= 16 && ma <= 21) return 3'h2;
    if (ma >= 25 && ma <= 31) return 3'h3;
    if (ma >= 35 && ma <= 45) return 3'h4;
    return 3'h7;
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic end_of_test();
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic note(input bit ok, input logic [15:0] g,
                      input logic [15:0] x);
    check_count++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp1(input logic g, input logic x);
    note(g === x, 16'(g), 16'(x));
  endtask
  task automatic cmp3(input logic [2:0] g, input logic [2:0] x);
    note(g === x, 16'(g), 16'(x));
  endtask
  task automatic cmp_span(input int g, input int lo, input int hi);
    note(g >= lo && g <= hi, 16'(g), 16'(lo));
  endtask
  task automatic bound(input int lim);
    if (n >= lim) begin
      note(1'b0, 16'(n), 16'(lim));
      end_of_test();
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
  endtask
  task automatic set_mode(input op_mode_e m, input logic ce);
    @(posedge clk);
    op_mode <= m;
    class_enable <= ce;
  endtask
  task automatic cmd(input int k);
    @(posedge clk);
    case (k)
      0: cmd_classify <= 1'h1;
      1: cmd_power_on <= 1'h1;
      2: cmd_power_off <= 1'h1;
      3: fault_clear <= 1'h1;
      4: det_req <= 1'h1;
      default: startup_fault <= 1'h1;
    endcase
    @(posedge clk);
    {cmd_classify, cmd_power_on, cmd_power_off} <= 3'h0;
    {fault_clear, det_req, startup_fault} <= 3'h0;
  endtask
  task automatic classify(input int k, input int ma);
    load_ma <= 8'(ma);
    cmd(k);
    n = 0;
    while (!probe.class_done && n < 40) begin
      @(negedge clk);
      n++;
    end
    bound(40);
    @(negedge clk);
  endtask
  task automatic no_class(input int k);
    s0 = starts;
    cmd(k);
    repeat (8) @(negedge clk);
    cmp_span(starts, s0, s0);
  endtask

  // ---
  // main sequence
  // ---
  initial begin
    do_reset();
    @(negedge clk);
    cmp1(gate_pull_down, 1'h1);
    repeat (4) begin
      lf = lfsr(lf);
      ma_q.push_back(int'(lf % 8'h30));
    end
    set_mode(MODE_SEMIAUTO, 1'h1);
    foreach (ma_q[i]) begin
      lf = lfsr(lf);
      @(posedge clk);
      slow <= lf[0];
      detect_enable <= lf[1];
      classify(4, ma_q[i]);
      e = exp_class(ma_q[i]);
      cmp3(status.class_code, e);
      cmp3(power_class, (e == 3'h4) ? 3'h0 : e);
      cmp1(gate_pull_up, 1'h0);
      cmp1(det_enable_eff, lf[1]);
    end
    set_mode(MODE_MANUAL, 1'h1);
    no_class(4);
    classify(0, 26);
    cmp3(status.class_code, 3'h3);
    set_mode(MODE_SEMIAUTO, 1'h0);
    no_class(4);
    cmp1(class_enable_eff, 1'h0);
    set_mode(MODE_AUTO, 1'h1);
    classify(4, 40);
    cmp1(gate_pull_up, 1'h1);
    no_class(4);
    cmd(5);
    @(negedge clk);
    cmp1(gate_pull_up, 1'h0);
    foreach (sel_q[i]) begin
      do_reset();
      set_mode(MODE_MANUAL, 1'h1);
      timing_cfg <= 8'(sel_q[i] << 2);
      cmd(1);
      @(negedge clk);
      cmp1(gate_pull_up, 1'h1);
      if (i == 0) begin
        cmd(2);
        @(negedge clk);
        cmp1(gate_pull_up, 1'h0);
        cmd(1);
      end
      @(posedge clk);
      oc_req <= i[0];
      pg_req <= !i[0];
      n = 0;
      while (gate_pull_up && n < 9000) begin
        @(negedge clk);
        n++;
      end
      bound(9000);
      cmp_span(n, 2 * full_q[sel_q[i]], 2 * full_q[sel_q[i]] + 10);
      cmp1(oc_fault_event, 1'h1);
      cmp1(status.oc_fault, 1'h1);
      cmp1(status.powered, 1'h0);
      @(posedge clk);
      {oc_req, pg_req} <= 2'h0;
      if (i == 1) begin
        set_mode(MODE_SHUTDOWN, 1'h1);
        repeat (2) @(negedge clk);
        cmp1(oc_fault_event, 1'h0);
      end
    end
    cmd(1);
    @(negedge clk);
    cmp1(gate_pull_up, 1'h0);
    cmd(3);
    @(negedge clk);
    cmp1(oc_fault_event, 1'h0);
    n = 0;
    while (status.oc_blocked && n < 20000) begin
      @(negedge clk);
      n++;
    end
    bound(20000);
    cmp_span(n, 32 * 480 - 60, 32 * 480 + 40);
    cmp1(gate_pull_up, 1'h0);
    cmd(1);
    @(negedge clk);
    cmp1(gate_pull_up, 1'h1);
    set_mode(MODE_SHUTDOWN, 1'h1);
    repeat (2) @(negedge clk);
    cmp1(gate_pull_up, 1'h0);
    end_of_test();
  end
endmodule
